// file: optcal_pkg.sv
// Package with constants and types for the optical auto-calibration controller
package optcal_pkg;

  // Detector and drive code widths (digital stand-ins for the analog paths)
  localparam int unsigned ADC_W   = 10;
  localparam int unsigned DRIVE_W = 8;

  // Calibrate line debounce: time in us and derived cycles at 125 MHz
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned DEBOUNCE_US      = 1000;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  // Ramp step interval: drive settles before the detector is judged
  localparam int unsigned RAMP_STEP_US     = 100;
  localparam int unsigned RAMP_STEP_CYC    = RAMP_STEP_US * CLK_MHZ;
  // Success light blink half period
  localparam int unsigned BLINK_HALF_MS    = 250;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_COUNT      = 3;

  // Drive code range: zero current up to the ceiling current
  localparam logic [DRIVE_W-1:0] DRIVE_ZERO = 8'h00;
  localparam logic [DRIVE_W-1:0] DRIVE_MAX  = 8'hFF;

  // Detector levels as fractions of full scale (supply)
  localparam logic [ADC_W-1:0] LVL_HALF  = 10'h200;
  localparam logic [ADC_W-1:0] LVL_UPPER = 10'h2AA;
  localparam logic [ADC_W-1:0] LVL_LOWER = 10'h155;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAMP,
    ST_SETTLE,
    ST_BLINK,
    ST_LOCKED,
    ST_FAIL
  } cal_state_t;

  // Indicator lights travelling together
  typedef struct packed {
    logic cal_ok;
    logic cal_fail;
    logic above;
    logic below;
  } lights_t;

  // Threshold logic outputs
  typedef struct packed {
    logic out_rise;
    logic out_fall;
  } logic_out_t;

  // Nonvolatile store port
  typedef struct packed {
    logic               wr;
    logic [DRIVE_W-1:0] data;
  } nv_wr_t;

endpackage : optcal_pkg

// file: line_debounce.sv
// Synchroniser and debouncer turning a grounded line into one start pulse
`timescale 1ns/100ps
`default_nettype none

module line_debounce
  import optcal_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // Raw line, active low
  input  wire logic line_b_i,
  // One-cycle pulse on each accepted grounding
  output logic      press_o
);

  localparam int unsigned CNT_W = $clog2(STABLE_CYC + 1);

  logic             sync1_r;
  logic             sync2_r;
  logic             stable_r;
  logic [CNT_W-1:0] cnt_r;

  // Two-stage synchroniser; idle line reads high
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= line_b_i;
      sync2_r <= sync1_r;
    end
  end

  // Level accepted only after it stays different for the whole window
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r    <= '0;
      stable_r <= 1'b1;
    end else if (sync2_r == stable_r) begin
      cnt_r <= '0;
    end else if (cnt_r == CNT_W'(STABLE_CYC - 1)) begin
      cnt_r    <= '0;
      stable_r <= sync2_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Falling edge of the filtered level gives one pulse per grounding
  assign press_o = (sync2_r == stable_r) ? 1'b0
                 : (stable_r && cnt_r == CNT_W'(STABLE_CYC - 1));

endmodule : line_debounce

`default_nettype wire

// file: optical_auto_calibration_ctrl.sv
// Top level: calibration sequencer, drive lock, indicators and trip outputs
// Overview of operation
// - Grounding calibrate line starts calibration
// - Ramp drive from zero until target
// - Target level is half of supply
// - Success light flashes exactly three times
// - Drive held until next calibrate grounding
// - Drive at maximum lights failure indicator
// - Locked setting kept in nonvolatile store
// - Rising output switches above two thirds
// - Falling output switches below one third
// - Lights show trips above and below calibration
`timescale 1ns/100ps
`default_nettype none

module optical_auto_calibration_ctrl
  import optcal_pkg::*;
#(
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned STEP_CYC  = RAMP_STEP_CYC,
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_b_i,
  // Remote calibrate line, grounded to request
  input  wire logic               cal_b_i,
  // Detector sample, full scale equals supply
  input  wire logic [ADC_W-1:0]   det_level_i,
  // Nonvolatile store: saved drive and valid flag read at start-up
  input  wire logic [DRIVE_W-1:0] nv_drive_i,
  input  wire logic               nv_valid_i,
  output nv_wr_t                  nv_wr_o,
  // Emitter drive code
  output logic [DRIVE_W-1:0]      drive_o,
  // Indicator lights and threshold outputs
  output lights_t                 lights_o,
  output logic_out_t              logic_o
);

  localparam int unsigned STEP_W  = $clog2(STEP_CYC + 1);
  localparam int unsigned BLINK_W = $clog2(BLINK_CYC + 1);

  cal_state_t          state_r;
  cal_state_t          state_nxt;
  logic                start;
  logic [STEP_W-1:0]   step_cnt_r;
  logic [BLINK_W-1:0]  blink_cnt_r;
  logic [2:0]          blinks_r;
  logic                blink_on_r;
  logic                loaded_r;
  logic [DRIVE_W-1:0]  drive_r;
  logic                step_done;
  logic                half_done;
  logic                at_target;
  logic_out_t          logic_r;
  lights_t             lights_r;
  nv_wr_t              nv_wr_r;

  line_debounce #(
    .STABLE_CYC (DEB_CYC)
  ) u_cal_deb (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .line_b_i   (cal_b_i),
    .press_o    (start)
  );

  assign step_done = (step_cnt_r == STEP_W'(STEP_CYC - 1));
  assign half_done = (blink_cnt_r == BLINK_W'(BLINK_CYC - 1));
  assign at_target = (det_level_i >= LVL_HALF);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (loaded_r) begin
          state_nxt = ST_LOCKED;
        end
      end
      ST_RAMP: begin
        if (step_done && at_target) begin
          state_nxt = ST_BLINK;
        end else if (step_done && drive_r == DRIVE_MAX) begin
          state_nxt = ST_FAIL;
        end
      end
      ST_BLINK: begin
        if (half_done && blink_on_r && blinks_r == 3'(BLINK_COUNT - 1)) begin
          state_nxt = ST_LOCKED;
        end
      end
      default: state_nxt = state_r;
    endcase
    if (start) begin
      state_nxt = ST_RAMP;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-shot load of the stored setting after reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loaded_r <= 1'b0;
    end else if (state_r == ST_IDLE && !loaded_r && nv_valid_i) begin
      loaded_r <= 1'b1;
    end
  end

  // Step timer gives the detector time to follow each drive change
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_cnt_r <= '0;
    end else if (start || state_r != ST_RAMP || step_done) begin
      step_cnt_r <= '0;
    end else begin
      step_cnt_r <= step_cnt_r + 1'b1;
    end
  end

  // Emitter drive
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_r <= DRIVE_ZERO;
    end else if (start) begin
      drive_r <= DRIVE_ZERO;
    end else if (state_r == ST_IDLE && nv_valid_i && !loaded_r) begin
      drive_r <= nv_drive_i;
    end else if (state_r == ST_RAMP && step_done && !at_target && drive_r != DRIVE_MAX) begin
      drive_r <= drive_r + 1'b1;
    end
  end

  // Blink timer and flash counter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_cnt_r <= '0;
      blinks_r    <= 3'h0;
      blink_on_r  <= 1'b0;
    end else if (state_r != ST_BLINK || start) begin
      blink_cnt_r <= '0;
      blinks_r    <= 3'h0;
      blink_on_r  <= (state_nxt == ST_BLINK) && !start;
    end else if (half_done) begin
      blink_cnt_r <= '0;
      blink_on_r  <= !blink_on_r;
      if (blink_on_r) begin
        blinks_r <= blinks_r + 3'h1;
      end
    end else begin
      blink_cnt_r <= blink_cnt_r + 1'b1;
    end
  end

  // Write locked setting once at the end of a calibration
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nv_wr_r <= '0;
    end else begin
      nv_wr_r.wr   <= (state_r == ST_BLINK) && (state_nxt == ST_LOCKED);
      nv_wr_r.data <= drive_r;
    end
  end

  // Threshold outputs, each with hysteresis between its trip point and the half level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      logic_r <= '0;
    end else begin
      if (det_level_i > LVL_UPPER) begin
        logic_r.out_rise <= 1'b1;
      end else if (det_level_i < LVL_HALF) begin
        logic_r.out_rise <= 1'b0;
      end
      if (det_level_i < LVL_LOWER) begin
        logic_r.out_fall <= 1'b1;
      end else if (det_level_i >= LVL_HALF) begin
        logic_r.out_fall <= 1'b0;
      end
    end
  end

  // Indicator lights; trip lights only meaningful once locked
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lights_r <= '0;
    end else begin
      lights_r.cal_ok   <= (state_r == ST_BLINK) && blink_on_r;
      lights_r.cal_fail <= (state_r == ST_FAIL);
      lights_r.above    <= (state_r == ST_LOCKED) && (det_level_i > LVL_UPPER);
      lights_r.below    <= (state_r == ST_LOCKED) && (det_level_i < LVL_LOWER);
    end
  end

  assign drive_o  = drive_r;
  assign lights_o = lights_r;
  assign logic_o  = logic_r;
  assign nv_wr_o  = nv_wr_r;

endmodule : optical_auto_calibration_ctrl

`default_nettype wire

// file: cal_monitor.sv
// Port checker for the optical calibration controller
`timescale 1ns/100ps
`default_nettype none
module cal_monitor
  import optcal_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
  // Clock, reset and inputs
  input wire logic               core_clk_i,
  input wire logic               rst_b_i,
  input wire logic               cal_b_i,
  input wire logic [ADC_W-1:0]   det_level_i,
  input wire logic               nv_valid_i,
  // Outputs
  input wire nv_wr_t             nv_wr_o,
  input wire logic [DRIVE_W-1:0] drive_o,
  input wire lights_t            lights_o,
  input wire logic_out_t         logic_o
);
  localparam int BL = BLINK_CYC;
  // Length of the current success-light on-phase; a counter and not a delay,
  // because the real half period runs to millions of cycles
  logic [31:0] ok_len_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // On-phase length counter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ok_len_r <= 32'h0;
    end else if (lights_o.cal_ok) begin
      ok_len_r <= ok_len_r + 32'h1;
    end else begin
      ok_len_r <= 32'h0;
    end
  end

  a_ramp_one_step: assert property (
    $changed(drive_o) && drive_o != 8'h00 && !nv_valid_i
    |-> drive_o == $past(drive_o) + 8'h01) else $error("drive jumped");
  a_blink_half: assert property (
    $fell(lights_o.cal_ok) |-> ok_len_r == 32'(BL)) else $error("blink length");
  a_lock_hold: assert property (
    (lights_o.above || lights_o.below) && cal_b_i && $past(cal_b_i, 8)
    |-> $stable(drive_o)) else $error("locked drive moved");
  a_fail_ceiling: assert property (
    $rose(lights_o.cal_fail) |-> drive_o == DRIVE_MAX) else $error("fail below ceiling");
  a_store_data: assert property (
    nv_wr_o.wr |-> nv_wr_o.data == drive_o && !lights_o.cal_fail) else $error("store data");
  a_rise_set: assert property (
    det_level_i > LVL_UPPER |=> logic_o.out_rise) else $error("rise not set");
  a_rise_clear: assert property (
    det_level_i < LVL_HALF |=> !logic_o.out_rise) else $error("rise not cleared");
  a_fall_set: assert property (
    det_level_i < LVL_LOWER |=> logic_o.out_fall) else $error("fall not set");
  a_fall_clear: assert property (
    det_level_i >= LVL_HALF |=> !logic_o.out_fall) else $error("fall not cleared");
endmodule : cal_monitor
bind optical_auto_calibration_ctrl cal_monitor #(.BLINK_CYC(BLINK_CYC)) cal_monitor_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cal_b_i(cal_b_i), .det_level_i(det_level_i),
  .nv_valid_i(nv_valid_i), .nv_wr_o(nv_wr_o), .drive_o(drive_o), .lights_o(lights_o),
  .logic_o(logic_o));
`default_nettype wire

// file: emitter_detector_model.sv
// Emitter and detector pair: detector level follows drive times coupling
`timescale 1ns/100ps
`default_nettype none
module emitter_detector_model
  import optcal_pkg::*;
(
  // Drive, coupling and outside light override
  input  wire logic [DRIVE_W-1:0] drive_i,
  input  wire logic [3:0]         gain_i,
  input  wire logic               ovr_en_i,
  input  wire logic [ADC_W-1:0]   ovr_level_i,
  // Detector sample
  output logic [ADC_W-1:0]        det_o
);
  logic [11:0] prod;
  // Saturates at full scale, as the transistor does at the rail
  assign prod  = 12'(drive_i) * 12'(gain_i);
  assign det_o = ovr_en_i ? ovr_level_i : (prod[9:0] | {10{|prod[11:10]}});
endmodule : emitter_detector_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the optical calibration controller
`timescale 1ns/100ps
`default_nettype none
module testbench
  import optcal_pkg::*;
;
  localparam logic [15:0] LOCK = 16'(LVL_HALF >> 3);
  logic               core_clk_i = 1'b0;
  logic               rst_b_i    = 1'b0;
  logic               cal_b_i    = 1'b1;
  logic [DRIVE_W-1:0] nv_drive   = 8'h00;
  logic               nv_valid   = 1'b0;
  logic [3:0]         gain       = 4'h8;
  logic               ovr_en     = 1'b0;
  logic [ADC_W-1:0]   ovr_lvl    = 10'h000;
  logic [ADC_W-1:0]   det;
  nv_wr_t             nv_wr;
  logic [DRIVE_W-1:0] drive;
  lights_t            lights;
  logic_out_t         lo;
  int                 n_errors   = 0;
  int                 cmp_count  = 0;

  optical_auto_calibration_ctrl #(.DEB_CYC(4), .STEP_CYC(4), .BLINK_CYC(8))
    optical_auto_calibration_ctrl_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .cal_b_i(cal_b_i), .det_level_i(det), .nv_drive_i(nv_drive), .nv_valid_i(nv_valid),
    .nv_wr_o(nv_wr), .drive_o(drive), .lights_o(lights), .logic_o(lo));
  emitter_detector_model emitter_detector_model_i (.drive_i(drive), .gain_i(gain),
    .ovr_en_i(ovr_en), .ovr_level_i(ovr_lvl), .det_o(det));

  // Clock, 8 ns period
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic do_reset(input logic vld, input logic [7:0] code);
    @(negedge core_clk_i);
    rst_b_i = 1'b0;
    nv_valid = vld;
    nv_drive = code;
    repeat (6) @(negedge core_clk_i);
    rst_b_i = 1'b1;
  endtask : do_reset

  task automatic press;
    @(negedge core_clk_i);
    cal_b_i = 1'b0;
    repeat (12) @(negedge core_clk_i);
    cal_b_i = 1'b1;
  endtask : press

  // Ramp to half scale, blink, lock
  task automatic t_cal_ok;
    int   blinks;
    logic prev;
    blinks = 0;
    prev = 1'b0;
    press();
    for (int i = 0; i < 2000 && nv_wr.wr !== 1'b1; i++) begin
      @(negedge core_clk_i);
      if (lights.cal_ok === 1'b1 && !prev) blinks++;
      prev = lights.cal_ok;
    end
    check(16'({nv_wr.wr, nv_wr.data}), LOCK | 16'h0100);
    check(16'(blinks), 16'h0003);
    repeat (30) @(negedge core_clk_i);
    check(16'(drive), LOCK);
  endtask : t_cal_ok

  // Trip points, then a glitch too short to count
  task automatic t_trip;
    ovr_en = 1'b1;
    ovr_lvl = LVL_UPPER;
    repeat (3) @(negedge core_clk_i);
    check(16'(lo.out_rise), 16'h0000);
    ovr_lvl = LVL_UPPER + 10'h001;
    repeat (3) @(negedge core_clk_i);
    check(16'({lo, lights.above, lights.below}), 16'h000A);
    ovr_lvl = LVL_LOWER - 10'h001;
    repeat (3) @(negedge core_clk_i);
    check(16'({lo, lights.above, lights.below}), 16'h0005);
    ovr_en = 1'b0;
    cal_b_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    cal_b_i = 1'b1;
    repeat (20) @(negedge core_clk_i);
    check(16'(drive), LOCK);
  endtask : t_trip

  // Weak coupling fails at ceiling; new press clears it
  task automatic t_fail;
    gain = 4'h1;
    press();
    for (int i = 0; i < 3000 && lights.cal_fail !== 1'b1; i++) @(negedge core_clk_i);
    check(16'({lights.cal_fail, drive}), 16'h01FF);
    gain = 4'h8;
    press();
    check(16'(lights.cal_fail), 16'h0000);
    for (int i = 0; i < 2000 && nv_wr.wr !== 1'b1; i++) @(negedge core_clk_i);
    check(16'(nv_wr.data), LOCK);
  endtask : t_fail

  // Power returns with a stored setting: no recalibration needed
  task automatic t_restore;
    do_reset(1'b1, 8'h5A);
    repeat (20) @(negedge core_clk_i);
    check(16'({nv_wr.wr, drive}), 16'h005A);
  endtask : t_restore

  // Main sequence
  initial begin
    do_reset(1'b0, 8'h00);
    check(16'({drive, lights, lo}), 16'h0000);
    t_cal_ok();
    t_trip();
    t_fail();
    t_restore();
    report_and_stop();
  end

  // Watchdog: scenarios need well under 8000 cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
